// file: src/ath_defines.svh
// Constants for the transfer-control block: offsets, fields, reset values
`ifndef ATH_DEFINES_SVH
`define ATH_DEFINES_SVH
// ****************************************
// Microcontroller register offsets
// ****************************************
`define ATH_ADDR_XCTL     16'hFF8B
`define ATH_ADDR_DRVSEL   16'hFF8C
`define ATH_ADDR_IREASON  16'hFF8D
`define ATH_ADDR_ERROR    16'hFF8E
`define ATH_ADDR_CMD      16'hFF8F
`define ATH_ADDR_STATUS   16'hFF87
`define ATH_ADDR_INTERFACE_STATUS   16'hFF92
`define ATH_ADDR_MAILBOX  16'hFF80
// ****************************************
// Host task-file selects
// ****************************************
`define ATH_HA_DATA       3'h0
`define ATH_HA_ERROR      3'h1
`define ATH_HA_IREASON    3'h2
`define ATH_HA_DRVSEL     3'h6
`define ATH_HA_CMD        3'h7
// ****************************************
// Fields and reset values
// ****************************************
`define ATH_XCTL_RST      8'h08
`define ATH_XCTL_MASK     8'h7F
`define ATH_DRVSEL_BIT    4
`define ATH_DRVSEL_ONES   8'hE0
`define ATH_IREASON_MASK  8'h07
`define ATH_ERROR_MASK    8'hFE
`define ATH_INTERFACE_STATUS_CMDI   7
`define ATH_STATUS_BSY    7
`define ATH_INTERFACE_STATUS_MBRDY  1
`define ATH_CMD_DIAG      8'h90
`define ATH_PKT_BYTES     4'hC
`define ATH_FIFO_DEPTH    32
`define ATH_FIFO_WIDTH    8
`endif

// file: src/ath_pkg.sv
// Types shared by the transfer-control block
package ath_pkg;
  typedef struct packed {
    logic       rsvd;
    logic       multi;
    logic       dma;
    logic       ultra;
    logic       own_drv;
    logic [2:0] route;
  } ath_xctl_t;

  typedef enum logic [2:0] {
    ATH_RT_TO_HOST  = 3'h0,
    ATH_RT_TO_MEM   = 3'h1,
    ATH_RT_PKT_IN   = 3'h4,
    ATH_RT_PKT_OUT  = 3'h5
  } ath_route_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ath_host_req_t;
endpackage

// file: src/ath_top.sv
// Transfer control, drive selection and command handling of the host port

`include "ath_defines.svh"

// ****************************************
// Mailbox FIFO
// ****************************************
module ath_fifo #(
  parameter int WIDTH = `ATH_FIFO_WIDTH,
  parameter int DEPTH = `ATH_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  // Filling side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Draining side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (count_ff != '0);
  assign out_data_out  = mem_ff[rd_ptr_ff];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      wr_ptr_ff <= push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
      rd_ptr_ff <= pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
      count_ff  <= (AW+1)'(count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end
endmodule

// ****************************************
// Top of the transfer-control block
// ****************************************
module ath_top (
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  // Microcontroller register port
  input  wire logic [15:0]       uc_addr_in,
  input  wire logic              uc_wr_in,
  input  wire logic              uc_rd_in,
  input  wire logic [7:0]        uc_wdata_in,
  output logic      [7:0]        uc_rdata_out,
  output logic                   cmd_irq_out,
  // Host task-file port
  input  wire ath_pkg::ath_host_req_t host_req_in,
  input  wire logic              host_irq_req_in,
  output logic      [7:0]        host_rdata_out,
  output logic                   host_irq_out,
  output logic                   host_irq_oe_out,
  output logic                   host_drq_out,
  // Transfer configuration
  output logic                   bsy_out,
  output logic                   selected_out,
  output logic                   path_dma_out,
  output logic                   dma_multi_out,
  output logic                   ultra_dma_out,
  output logic      [2:0]        route_out,
  output logic                   mbox_ready_out
);
  import ath_pkg::*;

  ath_xctl_t  xctl_ff;
  logic [7:0] drvsel_ff;
  logic [7:0] ireason_ff;
  logic [7:0] error_ff;
  logic [7:0] host_cmd_ff;
  logic       cmd_irq_ff;
  logic       bsy_ff;
  logic [3:0] pkt_cnt_ff;
  logic       init_seen_ff;

  // ****************************************
  // Address decode
  // ****************************************
  wire uc_wr_xctl    = uc_wr_in && (uc_addr_in == `ATH_ADDR_XCTL);
  wire uc_wr_drvsel  = uc_wr_in && (uc_addr_in == `ATH_ADDR_DRVSEL);
  wire uc_wr_ireason = uc_wr_in && (uc_addr_in == `ATH_ADDR_IREASON);
  wire uc_wr_error   = uc_wr_in && (uc_addr_in == `ATH_ADDR_ERROR);
  wire uc_wr_status  = uc_wr_in && (uc_addr_in == `ATH_ADDR_STATUS);
  wire uc_wr_interface_status  = uc_wr_in && (uc_addr_in == `ATH_ADDR_INTERFACE_STATUS);
  wire uc_wr_mbox    = uc_wr_in && (uc_addr_in == `ATH_ADDR_MAILBOX);
  wire uc_rd_cmd     = uc_rd_in && (uc_addr_in == `ATH_ADDR_CMD);
  wire uc_rd_mbox    = uc_rd_in && (uc_addr_in == `ATH_ADDR_MAILBOX);

  wire h_wr_drvsel  = host_req_in.wr && (host_req_in.addr == `ATH_HA_DRVSEL);
  wire h_wr_ireason = host_req_in.wr && (host_req_in.addr == `ATH_HA_IREASON);
  wire h_wr_cmd     = host_req_in.wr && (host_req_in.addr == `ATH_HA_CMD);
  wire h_wr_data    = host_req_in.wr && (host_req_in.addr == `ATH_HA_DATA);
  wire h_rd_data    = host_req_in.rd && (host_req_in.addr == `ATH_HA_DATA);

  // Selection follows both registers combinationally, so a drive number
  // change by either party takes effect on the very next command
  wire selected_w = (drvsel_ff[`ATH_DRVSEL_BIT] == xctl_ff.own_drv);

  // The diagnostic code reaches both drives of the cable
  wire cmd_event = h_wr_cmd &&
                   (selected_w || (host_req_in.wdata == `ATH_CMD_DIAG));
  wire cmd_clear = uc_rd_cmd ||
                   (uc_wr_interface_status && uc_wdata_in[`ATH_INTERFACE_STATUS_CMDI]);

  // ****************************************
  // Twelve-byte packet routes through the FIFO
  // ****************************************
  // Unlisted route codes fall through both tests and move nothing
  wire route_in  = (xctl_ff.route == ATH_RT_PKT_IN);
  wire route_out_w = (xctl_ff.route == ATH_RT_PKT_OUT);
  wire pkt_open  = (pkt_cnt_ff < `ATH_PKT_BYTES);

  logic       f_in_valid;
  logic       f_in_ready;
  logic [7:0] f_in_data;
  logic       f_out_valid;
  logic       f_out_ready;
  logic [7:0] f_out_data;

  assign f_in_valid  = route_in ? (h_wr_data && pkt_open) : (route_out_w && uc_wr_mbox);
  assign f_in_data   = route_in ? host_req_in.wdata : uc_wdata_in;
  assign f_out_ready = route_in ? uc_rd_mbox : (route_out_w && h_rd_data && pkt_open);

  // Host-side byte counts stop at twelve; a transfer-control write clears the byte counter
  wire host_beat = route_in ? (f_in_valid && f_in_ready) : (f_out_ready && f_out_valid);

  ath_fifo #(
    .WIDTH (`ATH_FIFO_WIDTH),
    .DEPTH (`ATH_FIFO_DEPTH)
  ) u_mbox (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .in_valid_in   (f_in_valid),
    .in_ready_out  (f_in_ready),
    .in_data_in    (f_in_data),
    .out_valid_out (f_out_valid),
    .out_ready_in  (f_out_ready),
    .out_data_out  (f_out_data)
  );

  // ****************************************
  // Register read selection
  // ****************************************
  wire [7:0] uc_rd_mux =
    (uc_addr_in == `ATH_ADDR_XCTL)    ? xctl_ff :
    (uc_addr_in == `ATH_ADDR_DRVSEL)  ? (drvsel_ff | `ATH_DRVSEL_ONES) :
    (uc_addr_in == `ATH_ADDR_IREASON) ? ireason_ff :
    (uc_addr_in == `ATH_ADDR_ERROR)   ? error_ff :
    (uc_addr_in == `ATH_ADDR_CMD)     ? host_cmd_ff :
    (uc_addr_in == `ATH_ADDR_STATUS)  ? {bsy_ff, 7'h00} :
    (uc_addr_in == `ATH_ADDR_INTERFACE_STATUS)  ? {cmd_irq_ff, 5'h00, f_in_ready, 1'b0} :
    (uc_addr_in == `ATH_ADDR_MAILBOX) ? f_out_data : 8'h00;

  // Command register has no host read path, so that select returns the busy status
  wire [7:0] h_rd_mux =
    (host_req_in.addr == `ATH_HA_DATA)    ? f_out_data :
    (host_req_in.addr == `ATH_HA_ERROR)   ? error_ff :
    (host_req_in.addr == `ATH_HA_IREASON) ? ireason_ff :
    (host_req_in.addr == `ATH_HA_DRVSEL)  ? (drvsel_ff | `ATH_DRVSEL_ONES) :
    (host_req_in.addr == `ATH_HA_CMD)     ? {bsy_ff, 7'h00} : 8'h00;

  // ****************************************
  // Register state
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      xctl_ff      <= `ATH_XCTL_RST;
      init_seen_ff <= 1'b0;
    end else if (uc_wr_xctl) begin
      xctl_ff      <= uc_wdata_in & `ATH_XCTL_MASK;
      init_seen_ff <= 1'b1;
    end
  end

  // Host write wins a collision: it is the party that owns selection
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      drvsel_ff <= 8'h00;
    end else if (h_wr_drvsel) begin
      drvsel_ff <= host_req_in.wdata & ~`ATH_DRVSEL_ONES;
    end else if (uc_wr_drvsel) begin
      drvsel_ff <= uc_wdata_in & ~`ATH_DRVSEL_ONES;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ireason_ff <= 8'h00;
      error_ff   <= 8'h00;
    end else begin
      if (uc_wr_ireason) begin
        ireason_ff <= uc_wdata_in & `ATH_IREASON_MASK;
      end else if (h_wr_ireason) begin
        ireason_ff <= host_req_in.wdata & `ATH_IREASON_MASK;
      end
      if (uc_wr_error) begin
        error_ff <= uc_wdata_in & `ATH_ERROR_MASK;
      end
    end
  end

  // Set beats clear so a command landing on the clear cycle is kept
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      host_cmd_ff <= 8'h00;
      cmd_irq_ff  <= 1'b0;
      bsy_ff      <= 1'b1;
    end else begin
      host_cmd_ff <= h_wr_cmd ? host_req_in.wdata : host_cmd_ff;
      cmd_irq_ff  <= cmd_event || (cmd_irq_ff && !cmd_clear);
      bsy_ff      <= cmd_event ? 1'b1 :
                     uc_wr_status ? uc_wdata_in[`ATH_STATUS_BSY] : bsy_ff;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pkt_cnt_ff <= 4'h0;
    end else if (uc_wr_xctl) begin
      pkt_cnt_ff <= 4'h0;
    end else if (host_beat) begin
      pkt_cnt_ff <= 4'(pkt_cnt_ff + 1'b1);
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      uc_rdata_out    <= 8'h00;
      host_rdata_out  <= 8'h00;
      host_irq_out    <= 1'b0;
      host_irq_oe_out <= 1'b0;
      host_drq_out    <= 1'b0;
      selected_out    <= 1'b0;
      path_dma_out    <= 1'b0;
      dma_multi_out   <= 1'b0;
      ultra_dma_out   <= 1'b0;
      route_out       <= 3'h0;
      mbox_ready_out  <= 1'b0;
    end else begin
      uc_rdata_out    <= uc_rd_in ? uc_rd_mux : uc_rdata_out;
      host_rdata_out  <= host_req_in.rd ? h_rd_mux : host_rdata_out;
      host_irq_out    <= host_irq_req_in && selected_w;
      host_irq_oe_out <= selected_w;
      host_drq_out    <= pkt_open && (route_in ? f_in_ready : (route_out_w && f_out_valid));
      selected_out    <= selected_w;
      path_dma_out    <= xctl_ff.dma;
      dma_multi_out   <= xctl_ff.multi;
      ultra_dma_out   <= xctl_ff.ultra;
      route_out       <= xctl_ff.route;
      mbox_ready_out  <= f_in_ready;
    end
  end

  assign cmd_irq_out = cmd_irq_ff;
  assign bsy_out     = bsy_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  chk_reset_ctl: assert property (!init_seen_ff |-> xctl_ff == `ATH_XCTL_RST)
    else $error("transfer control left its reset value without a write");
  chk_multi_sel: assert property (uc_wr_xctl |-> ##2 dma_multi_out == $past(uc_wdata_in[6], 2))
    else $error("multi-word output does not follow bit 6");
  chk_dma_sel: assert property (uc_wr_xctl |-> ##2 path_dma_out == $past(uc_wdata_in[5], 2))
    else $error("DMA path output does not follow bit 5");
  chk_own_drive: assert property (uc_wr_xctl |=> xctl_ff.own_drv == $past(uc_wdata_in[3]))
    else $error("own drive bit not taken from bit 3");
  chk_select_out: assert property (##1 selected_out == $past(selected_w))
    else $error("selected output disagrees with drive comparison");
  chk_irq_enable: assert property (host_irq_out |-> host_irq_oe_out && selected_out)
    else $error("host interrupt driven while not selected");
  chk_pkt_limit: assert property (pkt_cnt_ff <= `ATH_PKT_BYTES)
    else $error("packet route moved more than twelve bytes");
  chk_cmd_ro: assert property (uc_wr_in && uc_addr_in == `ATH_ADDR_CMD && !h_wr_cmd
                               |=> $stable(host_cmd_ff))
    else $error("micro write altered the command register");
  chk_cmd_raise: assert property (cmd_event |=> cmd_irq_out && bsy_out)
    else $error("command write did not raise interrupt and busy");
  chk_cmd_clear: assert property (cmd_irq_ff && cmd_clear && !cmd_event |=> !cmd_irq_out)
    else $error("command interrupt not cleared");
endmodule

// file: sim/ath_host_model.sv
// Host-side model: drives task-file accesses into the transfer-control block
`include "ath_defines.svh"

module ath_host_model (
  // Clock
  input  wire logic                   clk_sys_in,
  // Task-file access
  output ath_pkg::ath_host_req_t      host_req_out,
  input  wire logic [7:0]             host_rdata_in,
  // Status seen by the host
  input  wire logic                   bsy_in,
  input  wire logic                   drq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import ath_pkg::*;

  initial host_req_out = '0;

  // ****************************************
  // Accesses, launched and released on falling edges
  // ****************************************
  task automatic hwrite(input logic [2:0] a, input logic [7:0] d);
    int n = 0;
    while (a == `ATH_HA_CMD && (bsy_in !== 1'b0 || drq_in !== 1'b0) && n < 50) begin
      @(negedge clk_sys_in);
      n++;
    end
    // A busy flag that never drops counts against the run
    if (n >= 50) tb_top.error_cnt++;
    host_req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys_in);
    host_req_out.wr = 1'b0;
    // A released bus does not keep its last value
    host_req_out.wdata = ~d;
    repeat (2) @(negedge clk_sys_in);
  endtask

  task automatic hread(input logic [2:0] a, output logic [7:0] d);
    host_req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys_in);
    host_req_out.rd = 1'b0;
    d = host_rdata_in;
    @(negedge clk_sys_in);
  endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the transfer-control block
`include "ath_defines.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ath_pkg::*;

  logic          clk_sys_in = 1'b0;
  logic          rst_in = 1'b1;
  logic [15:0]   uc_addr_in = 16'h0000;
  logic          uc_wr_in = 1'b0;
  logic          uc_rd_in = 1'b0;
  logic [7:0]    uc_wdata_in = 8'h00;
  logic          host_irq_req_in = 1'b0;
  ath_host_req_t host_req;
  logic [7:0]    uc_rdata, host_rdata, rd;
  logic          cmd_irq, host_irq, host_irq_oe, host_drq, bsy, selected;
  logic          path_dma, dma_multi, ultra_dma, mbox_ready;
  logic [2:0]    route;
  logic [7:0]    modes [4] = '{8'h48, 8'h28, 8'h68, 8'h78};
  int            error_cnt = 0;
  int            cmp_count = 0;

  always #12.5 clk_sys_in = ~clk_sys_in;

  ath_top uut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .uc_addr_in(uc_addr_in), .uc_wr_in(uc_wr_in),
    .uc_rd_in(uc_rd_in), .uc_wdata_in(uc_wdata_in), .uc_rdata_out(uc_rdata),
    .cmd_irq_out(cmd_irq), .host_req_in(host_req), .host_irq_req_in(host_irq_req_in),
    .host_rdata_out(host_rdata), .host_irq_out(host_irq), .host_irq_oe_out(host_irq_oe),
    .host_drq_out(host_drq), .bsy_out(bsy), .selected_out(selected), .path_dma_out(path_dma),
    .dma_multi_out(dma_multi), .ultra_dma_out(ultra_dma), .route_out(route),
    .mbox_ready_out(mbox_ready));

  ath_host_model host (
    .clk_sys_in(clk_sys_in), .host_req_out(host_req), .host_rdata_in(host_rdata),
    .bsy_in(bsy), .drq_in(host_drq));

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d, comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************
  // Microcontroller port accesses
  // ****************************************
  task automatic uc_wr(input logic [15:0] a, input logic [7:0] d);
    uc_addr_in = a;
    uc_wdata_in = d;
    uc_wr_in = 1'b1;
    @(negedge clk_sys_in);
    uc_wr_in = 1'b0;
    // A released data bus does not keep the written value
    uc_wdata_in = ~d;
    // Derived outputs lag the register by a flop stage
    repeat (2) @(negedge clk_sys_in);
  endtask

  task automatic uc_rd(input logic [15:0] a, output logic [7:0] d);
    uc_addr_in = a;
    uc_rd_in = 1'b1;
    @(negedge clk_sys_in);
    uc_rd_in = 1'b0;
    d = uc_rdata;
    @(negedge clk_sys_in);
  endtask

  task automatic uc_chk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    uc_rd(a, d);
    check(d, exp);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (5) @(negedge clk_sys_in);
    check({7'h00, bsy}, 8'h01);
    rst_in = 1'b0;
    @(negedge clk_sys_in);
    uc_chk(`ATH_ADDR_XCTL, 8'h08);
    uc_chk(`ATH_ADDR_DRVSEL, 8'hE0);
    host_irq_req_in = 1'b1;
    check({6'h00, selected, host_irq_oe}, 8'h00);
    // Not selected: only the diagnostic code may reach the microcontroller
    uc_wr(`ATH_ADDR_STATUS, 8'h00);
    host.hwrite(`ATH_HA_CMD, 8'hA0);
    check({6'h00, cmd_irq, bsy}, 8'h00);
    host.hwrite(`ATH_HA_CMD, `ATH_CMD_DIAG);
    check({7'h00, cmd_irq}, 8'h01);
    uc_chk(`ATH_ADDR_CMD, `ATH_CMD_DIAG);
    check({7'h00, cmd_irq}, 8'h00);
    uc_wr(`ATH_ADDR_XCTL, 8'h00);
    check({5'h00, selected, host_irq_oe, host_irq}, 8'h07);
    uc_wr(`ATH_ADDR_STATUS, 8'h00);
    host.hwrite(`ATH_HA_CMD, 8'hA0);
    check({6'h00, cmd_irq, bsy}, 8'h03);
    // Host reads of the command select see status, never the command byte
    host.hread(`ATH_HA_CMD, rd);
    check(rd, 8'h80);
    uc_wr(`ATH_ADDR_CMD, 8'h55);
    uc_wr(`ATH_ADDR_INTERFACE_STATUS, 8'h80);
    check({7'h00, cmd_irq}, 8'h00);
    uc_chk(`ATH_ADDR_CMD, 8'hA0);
    host.hwrite(`ATH_HA_DRVSEL, 8'h10);
    host.hread(`ATH_HA_DRVSEL, rd);
    check(rd, 8'hF0);
    check({5'h00, selected, host_irq_oe, host_irq}, 8'h00);
    uc_wr(`ATH_ADDR_XCTL, 8'h08);
    check({7'h00, selected}, 8'h01);
    foreach (modes[i]) begin
      uc_wr(`ATH_ADDR_XCTL, modes[i]);
      check({5'h00, dma_multi, path_dma, ultra_dma}, {5'h00, modes[i][6:4]});
    end
    for (int r = 0; r < 8; r++) begin
      uc_wr(`ATH_ADDR_XCTL, 8'h08 | 8'(r));
      check({5'h00, route}, 8'(r));
    end
    uc_wr(`ATH_ADDR_IREASON, 8'hFF);
    uc_chk(`ATH_ADDR_IREASON, 8'h07);
    host.hwrite(`ATH_HA_IREASON, 8'h05);
    uc_chk(`ATH_ADDR_IREASON, 8'h05);
    uc_wr(`ATH_ADDR_ERROR, 8'hFF);
    host.hread(`ATH_HA_ERROR, rd);
    check(rd, 8'hFE);
    uc_wr(`ATH_ADDR_ERROR, 8'hA5);
    uc_chk(`ATH_ADDR_ERROR, 8'hA4);
    uc_chk(16'hFF00, 8'h00);
    // Host to micro packet; the thirteenth byte must be dropped
    uc_wr(`ATH_ADDR_XCTL, 8'h0C);
    for (int i = 0; i < 13; i++) host.hwrite(`ATH_HA_DATA, 8'h40 + 8'(i));
    for (int i = 0; i < 12; i++) uc_chk(`ATH_ADDR_MAILBOX, 8'h40 + 8'(i));
    // Micro to host: fill until refused while the host stalls, then drain
    uc_wr(`ATH_ADDR_XCTL, 8'h0D);
    for (int i = 0; i < 33; i++) uc_wr(`ATH_ADDR_MAILBOX, 8'h80 + 8'(i));
    check({6'h00, mbox_ready, host_drq}, 8'h01);
    uc_rd(`ATH_ADDR_INTERFACE_STATUS, rd);
    check({7'h00, rd[1]}, 8'h00);
    for (int i = 0; i < 32; i++) begin
      if (i == 12 || i == 24) uc_wr(`ATH_ADDR_XCTL, 8'h0D);
      host.hread(`ATH_HA_DATA, rd);
      check(rd, 8'h80 + 8'(i));
      if (i == 11) begin
        @(negedge clk_sys_in);
        check({7'h00, host_drq}, 8'h00);
      end
    end
    @(negedge clk_sys_in);
    check({6'h00, mbox_ready, host_drq}, 8'h02);
    // Second reset after transfer control and drive select were rewritten
    rst_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    check({7'h00, bsy}, 8'h01);
    rst_in = 1'b0;
    @(negedge clk_sys_in);
    uc_chk(`ATH_ADDR_XCTL, 8'h08);
    check({7'h00, selected}, 8'h00);
    end_sim();
  end
endmodule
